//--- hdl/gwa_pkg.sv
package gwa_pkg;
    // ------------------------------------------------------------
    // register geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int BASE_W = 24;
    localparam int PIX_W = 11;
    localparam int HIGH_W = 8;
    localparam int LOW_W = 16;

    // ------------------------------------------------------------
    // register offsets (word index)
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_AREA1_LOW = 4'h0;
    localparam logic [3:0] OFS_AREA1_HIGH = 4'h1;
    localparam logic [3:0] OFS_AREA2_LOW = 4'h2;
    localparam logic [3:0] OFS_AREA2_HIGH = 4'h3;
    localparam logic [3:0] OFS_AREA_WIDTH = 4'h4;
    localparam logic [3:0] OFS_AREA_HEIGHT = 4'h5;
    localparam logic [3:0] OFS_FRAME_LOW = 4'h6;
    localparam logic [3:0] OFS_FRAME_HIGH = 4'h7;
    localparam logic [3:0] OFS_FRAME_WIDTH = 4'h8;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_LOW = 16'h0000;
    localparam logic [7:0] RST_HIGH = 8'h00;
    localparam logic [10:0] RST_PIX = 11'h000;
    localparam logic [15:0] READ_UNMAPPED = 16'h0000;
endpackage

//--- hdl/gwa_bus_if.sv
interface gwa_bus_if;
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic [15:0] rdata;
    modport master (output addr, output wdata, output wr, output rd, input rdata);
    modport slave (input addr, input wdata, input wr, input rd, output rdata);
endinterface

//--- hdl/gwa_field.sv
module gwa_field #(
    parameter int W = 16,
    parameter logic [W-1:0] RST = '0
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    input wire logic enable,
    // write port
    input wire logic load,
    input wire logic [W-1:0] din,
    // stored value
    output logic [W-1:0] q
);
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            q <= RST;
        end else if (enable && load) begin
            q <= din;
        end
    end
endmodule

//--- hdl/gwa_regs.sv
// Overview of operation
// - first area base is high register low byte over low register word.
// - second area base is high register low byte over low register word.
// - frame base is high register low byte over low register word.
// - area pixel width is eleven bits, bits 10-0.
// - area pixel height is eleven bits, bits 10-0.
// - frame pixel width is eleven bits, bits 10-0.
// - high address registers read zero in bits 15-8.
// - width and height registers read zero in bits 15-11.
module gwa_regs (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    input wire logic clk_en,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // configuration outputs
    output logic [23:0] first_area_base,
    output logic [23:0] second_area_base,
    output logic [23:0] frame_base,
    output logic [10:0] area_pixel_width,
    output logic [10:0] area_pixel_height,
    output logic [10:0] frame_pixel_width
);
    // ------------------------------------------------------------
    // internal bus
    // ------------------------------------------------------------
    gwa_bus_if bus ();
    assign bus.addr = reg_addr;
    assign bus.wdata = reg_wdata;
    assign bus.wr = reg_wr;
    assign bus.rd = reg_rd;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
        hit = (a == ofs);
    endfunction

    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    wire logic wr_a1l = bus.wr && hit(bus.addr, gwa_pkg::OFS_AREA1_LOW);
    wire logic wr_a1h = bus.wr && hit(bus.addr, gwa_pkg::OFS_AREA1_HIGH);
    wire logic wr_a2l = bus.wr && hit(bus.addr, gwa_pkg::OFS_AREA2_LOW);
    wire logic wr_a2h = bus.wr && hit(bus.addr, gwa_pkg::OFS_AREA2_HIGH);
    wire logic wr_aw = bus.wr && hit(bus.addr, gwa_pkg::OFS_AREA_WIDTH);
    wire logic wr_ah = bus.wr && hit(bus.addr, gwa_pkg::OFS_AREA_HEIGHT);
    wire logic wr_fl = bus.wr && hit(bus.addr, gwa_pkg::OFS_FRAME_LOW);
    wire logic wr_fh = bus.wr && hit(bus.addr, gwa_pkg::OFS_FRAME_HIGH);
    wire logic wr_fw = bus.wr && hit(bus.addr, gwa_pkg::OFS_FRAME_WIDTH);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [15:0] a1l_r, a2l_r, fl_r;
    logic [7:0] a1h_r, a2h_r, fh_r;
    logic [10:0] aw_r, ah_r, fw_r;

    gwa_field #(.W(16), .RST(gwa_pkg::RST_LOW)) u_a1l (
        .clock(clock),
        .resetn(resetn),
        .enable(clk_en),
        .load(wr_a1l),
        .din(bus.wdata),
        .q(a1l_r)
    );
    gwa_field #(.W(16), .RST(gwa_pkg::RST_LOW)) u_a2l (
        .clock(clock),
        .resetn(resetn),
        .enable(clk_en),
        .load(wr_a2l),
        .din(bus.wdata),
        .q(a2l_r)
    );
    gwa_field #(.W(16), .RST(gwa_pkg::RST_LOW)) u_fl (
        .clock(clock),
        .resetn(resetn),
        .enable(clk_en),
        .load(wr_fl),
        .din(bus.wdata),
        .q(fl_r)
    );

    gwa_field #(.W(8), .RST(gwa_pkg::RST_HIGH)) u_a1h (
        .clock(clock),
        .resetn(resetn),
        .enable(clk_en),
        .load(wr_a1h),
        .din(bus.wdata[7:0]),
        .q(a1h_r)
    );
    gwa_field #(.W(8), .RST(gwa_pkg::RST_HIGH)) u_a2h (
        .clock(clock),
        .resetn(resetn),
        .enable(clk_en),
        .load(wr_a2h),
        .din(bus.wdata[7:0]),
        .q(a2h_r)
    );
    gwa_field #(.W(8), .RST(gwa_pkg::RST_HIGH)) u_fh (
        .clock(clock),
        .resetn(resetn),
        .enable(clk_en),
        .load(wr_fh),
        .din(bus.wdata[7:0]),
        .q(fh_r)
    );

    gwa_field #(.W(11), .RST(gwa_pkg::RST_PIX)) u_aw (
        .clock(clock),
        .resetn(resetn),
        .enable(clk_en),
        .load(wr_aw),
        .din(bus.wdata[10:0]),
        .q(aw_r)
    );
    gwa_field #(.W(11), .RST(gwa_pkg::RST_PIX)) u_ah (
        .clock(clock),
        .resetn(resetn),
        .enable(clk_en),
        .load(wr_ah),
        .din(bus.wdata[10:0]),
        .q(ah_r)
    );
    gwa_field #(.W(11), .RST(gwa_pkg::RST_PIX)) u_fw (
        .clock(clock),
        .resetn(resetn),
        .enable(clk_en),
        .load(wr_fw),
        .din(bus.wdata[10:0]),
        .q(fw_r)
    );

    // ------------------------------------------------------------
    // address assembly
    // ------------------------------------------------------------
    // first area base
    assign first_area_base = {a1h_r, a1l_r};
    assign second_area_base = {a2h_r, a2l_r};
    assign frame_base = {fh_r, fl_r};
    assign area_pixel_width = aw_r;
    assign area_pixel_height = ah_r;
    assign frame_pixel_width = fw_r;

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic [15:0] rd_sel;
    logic [15:0] rdata_r;
    wire logic [15:0] rd_a1h = {8'h00, a1h_r};
    wire logic [15:0] rd_a2h = {8'h00, a2h_r};
    wire logic [15:0] rd_fh = {8'h00, fh_r};
    wire logic [15:0] rd_aw = {5'h00, aw_r};
    wire logic [15:0] rd_ah = {5'h00, ah_r};
    wire logic [15:0] rd_fw = {5'h00, fw_r};

    always_comb begin
        case (bus.addr)
            gwa_pkg::OFS_AREA1_LOW: rd_sel = a1l_r;
            gwa_pkg::OFS_AREA1_HIGH: rd_sel = rd_a1h;
            gwa_pkg::OFS_AREA2_LOW: rd_sel = a2l_r;
            gwa_pkg::OFS_AREA2_HIGH: rd_sel = rd_a2h;
            gwa_pkg::OFS_AREA_WIDTH: rd_sel = rd_aw;
            gwa_pkg::OFS_AREA_HEIGHT: rd_sel = rd_ah;
            gwa_pkg::OFS_FRAME_LOW: rd_sel = fl_r;
            gwa_pkg::OFS_FRAME_HIGH: rd_sel = rd_fh;
            gwa_pkg::OFS_FRAME_WIDTH: rd_sel = rd_fw;
            default: rd_sel = gwa_pkg::READ_UNMAPPED;
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rdata_r <= 16'h0000;
        end else if (clk_en) begin
            rdata_r <= bus.rd ? rd_sel : 16'h0000;
        end
    end
    assign bus.rdata = rdata_r;
    assign reg_rdata = bus.rdata;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_high_pad_zero: assert property (@(posedge clock) disable iff (!resetn)
        clk_en && reg_rd && (reg_addr == gwa_pkg::OFS_AREA1_HIGH
        || reg_addr == gwa_pkg::OFS_AREA2_HIGH || reg_addr == gwa_pkg::OFS_FRAME_HIGH)
        |=> reg_rdata[15:8] == 8'h00)
        else $error("high register upper byte not zero");
    a_pix_pad_zero: assert property (@(posedge clock) disable iff (!resetn)
        clk_en && reg_rd && (reg_addr == gwa_pkg::OFS_AREA_WIDTH
        || reg_addr == gwa_pkg::OFS_AREA_HEIGHT || reg_addr == gwa_pkg::OFS_FRAME_WIDTH)
        |=> reg_rdata[15:11] == 5'h00)
        else $error("pixel register upper bits not zero");
    a_first_base_wr: assert property (@(posedge clock) disable iff (!resetn)
        clk_en && reg_wr && reg_addr == gwa_pkg::OFS_AREA1_HIGH
        |=> first_area_base[23:16] == $past(reg_wdata[7:0]))
        else $error("first area base high byte not loaded");
    a_second_base_wr: assert property (@(posedge clock) disable iff (!resetn)
        clk_en && reg_wr && reg_addr == gwa_pkg::OFS_AREA2_LOW
        |=> second_area_base[15:0] == $past(reg_wdata) && $stable(second_area_base[23:16]))
        else $error("second area base low word not loaded");
    a_frame_base_wr: assert property (@(posedge clock) disable iff (!resetn)
        clk_en && reg_wr && reg_addr == gwa_pkg::OFS_FRAME_HIGH
        |=> frame_base[23:16] == $past(reg_wdata[7:0]) && $stable(frame_base[15:0]))
        else $error("frame base high byte not loaded");
    a_area_width_wr: assert property (@(posedge clock) disable iff (!resetn)
        clk_en && reg_wr && reg_addr == gwa_pkg::OFS_AREA_WIDTH
        |=> area_pixel_width == $past(reg_wdata[10:0]))
        else $error("area width not loaded");
    a_area_height_wr: assert property (@(posedge clock) disable iff (!resetn)
        clk_en && reg_wr && reg_addr == gwa_pkg::OFS_AREA_HEIGHT
        |=> area_pixel_height == $past(reg_wdata[10:0]))
        else $error("area height not loaded");
    a_frame_width_rd: assert property (@(posedge clock) disable iff (!resetn)
        clk_en && reg_wr && reg_addr == gwa_pkg::OFS_FRAME_WIDTH
        ##1 clk_en && reg_rd && reg_addr == gwa_pkg::OFS_FRAME_WIDTH
        |=> reg_rdata == {5'h00, $past(reg_wdata[10:0], 2)})
        else $error("frame width readback wrong");
    a_frozen_hold: assert property (@(posedge clock) disable iff (!resetn)
        !clk_en |=> $stable(first_area_base) && $stable(frame_base) && $stable(reg_rdata))
        else $error("state changed while clock enable low");
    a_first_low_wr: assert property (@(posedge clock) disable iff (!resetn)
        clk_en && reg_wr && reg_addr == gwa_pkg::OFS_AREA1_LOW
        |=> first_area_base[15:0] == $past(reg_wdata) && $stable(first_area_base[23:16]))
        else $error("first area base low word not loaded");
    a_second_high_wr: assert property (@(posedge clock) disable iff (!resetn)
        clk_en && reg_wr && reg_addr == gwa_pkg::OFS_AREA2_HIGH
        |=> second_area_base[23:16] == $past(reg_wdata[7:0]) && $stable(second_area_base[15:0]))
        else $error("second area base high byte not loaded");
    a_frame_low_wr: assert property (@(posedge clock) disable iff (!resetn)
        clk_en && reg_wr && reg_addr == gwa_pkg::OFS_FRAME_LOW
        |=> frame_base[15:0] == $past(reg_wdata) && $stable(frame_base[23:16]))
        else $error("frame base low word not loaded");
    a_high_drop_rd: assert property (@(posedge clock) disable iff (!resetn)
        clk_en && reg_wr && reg_addr == gwa_pkg::OFS_AREA1_HIGH
        ##1 clk_en && reg_rd && reg_addr == gwa_pkg::OFS_AREA1_HIGH
        |=> reg_rdata == {8'h00, $past(reg_wdata[7:0], 2)})
        else $error("high register readback wrong");
    a_second_low_rd: assert property (@(posedge clock) disable iff (!resetn)
        clk_en && reg_wr && reg_addr == gwa_pkg::OFS_AREA2_LOW
        ##1 clk_en && reg_rd && reg_addr == gwa_pkg::OFS_AREA2_LOW
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("second area low word readback wrong");

    // ------------------------------------------------------------
    // hold checks
    // ------------------------------------------------------------
    a_first_base_hold: assert property (@(posedge clock) disable iff (!resetn)
        !(clk_en && reg_wr && (reg_addr == gwa_pkg::OFS_AREA1_LOW
        || reg_addr == gwa_pkg::OFS_AREA1_HIGH)) |=> $stable(first_area_base))
        else $error("first area base changed without a write");
    a_second_base_hold: assert property (@(posedge clock) disable iff (!resetn)
        !(clk_en && reg_wr && (reg_addr == gwa_pkg::OFS_AREA2_LOW
        || reg_addr == gwa_pkg::OFS_AREA2_HIGH)) |=> $stable(second_area_base))
        else $error("second area base changed without a write");
    a_frame_base_hold: assert property (@(posedge clock) disable iff (!resetn)
        !(clk_en && reg_wr && (reg_addr == gwa_pkg::OFS_FRAME_LOW
        || reg_addr == gwa_pkg::OFS_FRAME_HIGH)) |=> $stable(frame_base))
        else $error("frame base changed without a write");
    a_area_width_hold: assert property (@(posedge clock) disable iff (!resetn)
        !(clk_en && reg_wr && reg_addr == gwa_pkg::OFS_AREA_WIDTH)
        |=> $stable(area_pixel_width))
        else $error("area width changed without a write");
    a_area_height_hold: assert property (@(posedge clock) disable iff (!resetn)
        !(clk_en && reg_wr && reg_addr == gwa_pkg::OFS_AREA_HEIGHT)
        |=> $stable(area_pixel_height))
        else $error("area height changed without a write");
    a_frame_width_hold: assert property (@(posedge clock) disable iff (!resetn)
        !(clk_en && reg_wr && reg_addr == gwa_pkg::OFS_FRAME_WIDTH)
        |=> $stable(frame_pixel_width))
        else $error("frame width changed without a write");

    c_write_high: cover property (@(posedge clock) disable iff (!resetn)
        clk_en && reg_wr && reg_addr == gwa_pkg::OFS_AREA1_HIGH && reg_wdata[15:8] != 8'h00);
    c_read_width: cover property (@(posedge clock) disable iff (!resetn)
        clk_en && reg_rd && reg_addr == gwa_pkg::OFS_AREA_WIDTH);
    c_back_to_back: cover property (@(posedge clock) disable iff (!resetn)
        clk_en && reg_wr ##1 clk_en && reg_rd);
    c_unmapped_read: cover property (@(posedge clock) disable iff (!resetn)
        clk_en && reg_rd && reg_addr > gwa_pkg::OFS_FRAME_WIDTH);
    c_frozen_write: cover property (@(posedge clock) disable iff (!resetn)
        !clk_en && reg_wr);
endmodule

//--- tb/tb_gwa_regs.sv
module tb_gwa_regs;
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic clk_en = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [23:0] first_area_base, second_area_base, frame_base;
    logic [10:0] area_pixel_width, area_pixel_height, frame_pixel_width;
    logic [15:0] exp_r [16];
    logic [15:0] q [$];
    logic rd_pend = 1'b0;
    logic [31:0] seed = 32'h000181BB;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #25 clock = ~clock;

    gwa_regs dut (.clock(clock), .resetn(resetn), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .first_area_base(first_area_base), .second_area_base(second_area_base),
        .frame_base(frame_base), .area_pixel_width(area_pixel_width),
        .area_pixel_height(area_pixel_height), .frame_pixel_width(frame_pixel_width));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] msk(input logic [3:0] a);
        case (a)
            gwa_pkg::OFS_AREA1_LOW, gwa_pkg::OFS_AREA2_LOW, gwa_pkg::OFS_FRAME_LOW:
                return 16'hFFFF;
            gwa_pkg::OFS_AREA1_HIGH, gwa_pkg::OFS_AREA2_HIGH, gwa_pkg::OFS_FRAME_HIGH:
                return 16'h00FF;
            gwa_pkg::OFS_AREA_WIDTH, gwa_pkg::OFS_AREA_HEIGHT, gwa_pkg::OFS_FRAME_WIDTH:
                return 16'h07FF;
            default: return 16'h0000;
        endcase
    endfunction

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic test_done();
        $display("checked %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic cmp_rd(input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (e !== g) begin
            n_mismatch++;
            $display("[ERR] reg_rdata expected %h seen %h", e, g);
        end
    endtask

    task automatic cmp_cfg(input string n, input logic [23:0] e, input logic [23:0] g);
        samples_checked++;
        if (e !== g) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    // one bus cycle; the model follows every accepted write
    task automatic put(input logic e, input logic w, input logic r, input logic [3:0] a,
                       input logic [15:0] d);
        clk_en <= e;
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        if (r && e) begin
            q.push_back(exp_r[a]);
        end
        if (w && e) begin
            exp_r[a] = d & msk(a);
        end
        @(posedge clock);
    endtask

    task automatic chk_cfg();
        put(1'b1, 1'b0, 1'b0, 4'h0, 16'h0000);
        @(negedge clock);
        cmp_cfg("first_area_base", {exp_r[1][7:0], exp_r[0]}, first_area_base);
        cmp_cfg("second_area_base", {exp_r[3][7:0], exp_r[2]}, second_area_base);
        cmp_cfg("frame_base", {exp_r[7][7:0], exp_r[6]}, frame_base);
        cmp_cfg("area_pixel_width", {13'h0, exp_r[4][10:0]}, {13'h0, area_pixel_width});
        cmp_cfg("area_pixel_height", {13'h0, exp_r[5][10:0]}, {13'h0, area_pixel_height});
        cmp_cfg("frame_pixel_width", {13'h0, exp_r[8][10:0]}, {13'h0, frame_pixel_width});
        @(posedge clock);
    endtask

    task automatic read_all();
        for (int a = 0; a < 16; a++) begin
            put(1'b1, 1'b0, 1'b1, a[3:0], 16'h0000);
        end
    endtask

    // ------------------------------------------------------------
    // read monitor
    // ------------------------------------------------------------
    always @(posedge clock) begin
        rd_pend <= reg_rd && clk_en && resetn;
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            test_done();
        end
    end

    always @(negedge clock) begin
        if (rd_pend) begin
            cmp_rd(q.pop_front(), reg_rdata);
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        for (int a = 0; a < 16; a++) begin
            exp_r[a] = 16'h0000;
        end
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        read_all();
        chk_cfg();
        for (int k = 0; k < 4; k++) begin
            for (int a = 0; a < 16; a++) begin
                seed = lfsr(seed);
                put(1'b1, 1'b1, 1'b0, a[3:0],
                    (msk(a[3:0]) == 16'hFFFF) ? {seed[15:1], 1'b0} : seed[15:0]);
            end
            read_all();
            chk_cfg();
        end
        // strobes with the clock enable low are ignored
        put(1'b0, 1'b1, 1'b0, 4'h1, 16'hFFFF);
        put(1'b0, 1'b1, 1'b0, 4'h8, 16'hFFFF);
        put(1'b1, 1'b1, 1'b0, 4'h2, 16'hFFFE);
        put(1'b1, 1'b0, 1'b1, 4'h2, 16'h0000);
        put(1'b1, 1'b1, 1'b0, 4'h8, 16'hFABC);
        put(1'b1, 1'b0, 1'b1, 4'h8, 16'h0000);
        put(1'b1, 1'b1, 1'b0, 4'h1, 16'hA55A);
        put(1'b1, 1'b0, 1'b1, 4'h1, 16'h0000);
        put(1'b0, 1'b0, 1'b1, 4'h1, 16'h0000);
        read_all();
        chk_cfg();
        // reset in mid-run clears every field
        resetn <= 1'b0;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        for (int a = 0; a < 16; a++) begin
            exp_r[a] = 16'h0000;
        end
        @(posedge clock);
        chk_cfg();
        read_all();
        put(1'b1, 1'b0, 1'b0, 4'h0, 16'h0000);
        repeat (2) @(posedge clock);
        test_done();
    end
endmodule
